// ===== hw/cvm_regs.svh
`ifndef CVM_REGS_SVH
`define CVM_REGS_SVH
// Register byte offsets on the AXI4-Lite port.
`define CVM_OFS_CTRL 8'h00
`define CVM_OFS_STAT 8'h04
`define CVM_OFS_CNT 8'h08
`define CVM_OFS_RES 8'h0C
`define CVM_OFS_IST 8'h10
`define CVM_OFS_IMSK 8'h14
// Control bits; start, stop, clear and inject are self-clearing strobes.
`define CVM_B_START 0
`define CVM_B_STOP 1
`define CVM_B_CLR 2
`define CVM_B_TOTAL 3
`define CVM_B_CHK 4
`define CVM_B_INJ 5
`define CVM_F_CODE 9:8
`define CVM_F_RATE 11:10
// Status bits.
`define CVM_B_SIG 0
`define CVM_B_RUN 1
`define CVM_B_OVF 2
// Interrupt status and mask bits.
`define CVM_I_WIN 0
`define CVM_I_OVF 1
`define CVM_I_LOS 2
`define CVM_I_CV 3
// Reset values and limits.
`define CVM_MSK_RST 4'h0
`define CVM_CODES_OK 4'hF
`define CVM_CNT_MAX 20'h99999
`define CVM_WIN_SLOTS 1000000
`define CVM_PRES_RUN 4'h8
// Clock and line rates in kHz and kbit/s.
`define CVM_SYS_KHZ 20000
`define CVM_KBPS_1544 1544
`define CVM_KBPS_2048 2048
`define CVM_KBPS_6312 6312
`define CVM_KBPS_8448 8448
`endif

// ===== hw/cvm_pkg.sv
package cvm_pkg;
	// Line code selection.
	typedef enum logic [1:0] {
		CODE_AMI = 2'h0,
		CODE_HDB3 = 2'h1,
		CODE_B6ZS = 2'h2,
		CODE_B8ZS = 2'h3
	} cvm_code_e;
	// Measurement state, one-hot.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN = 2'h2
	} cvm_state_e;
endpackage

// ===== hw/cvm_sym_if.sv
`timescale 1ns/100ps
interface cvm_sym_if;
	import cvm_pkg::*;
	logic symValid;
	logic symPos;
	logic symNeg;
	cvm_code_e code;
	logic violation;
	modport mon (output symValid, output symPos, output symNeg, output code, input violation);
	modport det (input symValid, input symPos, input symNeg, input code, output violation);
endinterface

// ===== hw/cvm_cv_detect.sv
`timescale 1ns/100ps
module cvm_cv_detect import cvm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	cvm_sym_if.det sym
);
	logic mark;
	logic bpv;
	logic subst;
	logic lastPol_reg;
	logic haveMark_reg;
	logic lastBpvPol_reg;
	logic haveBpv_reg;
	logic viol_reg;
	logic [7:0] hMark_reg;
	logic [7:0] hPol_reg;
	logic [7:0] hBpv_reg;

	// A bipolar violation is a mark with the polarity of the previous mark.
	assign mark = sym.symPos | sym.symNeg;
	assign bpv = mark & haveMark_reg & (sym.symPos == lastPol_reg);
	// Substitution shape ending now: M1(bpv) M2 0 M3 M4, zeros ahead of M1.
	// R3 R4 - pattern recognition
	assign subst = mark & hMark_reg[0] & ~hMark_reg[1] & hMark_reg[2] & hMark_reg[3]
		& hBpv_reg[3] & (hPol_reg[2] != hPol_reg[3]) & (hPol_reg[0] == hPol_reg[2])
		& (sym.symPos != hPol_reg[0]) & ~hMark_reg[4]
		& ((sym.code == CODE_B6ZS) | ~(hMark_reg[5] | hMark_reg[6]));
	assign sym.violation = viol_reg;

	// Mark and violation polarity history.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lastPol_reg <= 1'b0;
			haveMark_reg <= 1'b0;
			lastBpvPol_reg <= 1'b0;
			haveBpv_reg <= 1'b0;
		end else if (sym.symValid && mark) begin
			lastPol_reg <= sym.symPos;
			haveMark_reg <= 1'b1;
			if (bpv) begin
				lastBpvPol_reg <= sym.symPos;
				haveBpv_reg <= 1'b1;
			end
		end
	end

	// Eight-slot delay line so substitution violations can be excused late.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hMark_reg <= 8'h00;
			hPol_reg <= 8'h00;
			hBpv_reg <= 8'h00;
		end else if (sym.symValid) begin
			hMark_reg <= {hMark_reg[6:0], mark};
			hPol_reg <= {hPol_reg[6:0], sym.symPos};
			// R3 R4 - excuse inserted violations
			hBpv_reg <= {hBpv_reg[6:4], hBpv_reg[3] & ~subst, hBpv_reg[2:1],
				hBpv_reg[0] & ~subst, bpv};
		end
	end

	// Per-code decision; zero runs are never judged.
	// R5 - polarity only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			viol_reg <= 1'b0;
		end else begin
			case (sym.code)
				// R1 - same polarity marks
				CODE_AMI: viol_reg <= sym.symValid & bpv;
				// R2 - paired violations
				CODE_HDB3: viol_reg <= sym.symValid & bpv & haveBpv_reg
					& (sym.symPos == lastBpvPol_reg);
				default: viol_reg <= sym.symValid & hBpv_reg[7];
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_amiViol;
		(sym.code == CODE_AMI) && sym.symValid && bpv |=> sym.violation;
	endproperty
	a_amiViol: assert property (p_amiViol) else $error("AMI violation missed"); // R1
	property p_hdbOnlyBpv;
		(sym.code == CODE_HDB3) && !(sym.symValid && bpv) |=> !sym.violation;
	endproperty
	a_hdbOnlyBpv: assert property (p_hdbOnlyBpv) else $error("HDB3 flag w/o BPV"); // R2
endmodule // cvm_cv_detect

// ===== hw/cvm_monitor.sv
// Operation
// R1 - AMI: same-polarity successive marks are violations
// R2 - HDB3: same-polarity successive bipolar violations count
// R3 - B6ZS: excuse substitution violations, count others
// R4 - B8ZS: excuse substitution violations, count others
// R5 - zero runs are not judged
// R6 - rates 1544, 2048, 6312, 8448 selectable
// R7 - supported code subset is configurable
// R8 - sample each slot at recovered mid-slot edge
// R9 - signal present on amplitude and rate
// R10 - rate from violations per window slots
// R11 - cumulative total as alternative mode
// R12 - count to 99999, then overflow flag
// R13 - start begins counting, stop ends it
// R14 - clear wipes counter, overflow and result
// R15 - check exercises counter, display, input path
// R16 - injected input violations follow code definitions
// R17 - result output as parallel BCD digits
// R18 - overflow holds maximum until clear; in rate mode a window end also drops the flag and restarts the counter
// R19 - no counting while signal absent
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "cvm_regs.svh"
module cvm_monitor import cvm_pkg::*; #(
	parameter int unsigned WIN_SLOTS = `CVM_WIN_SLOTS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic linkClk,
	input wire logic linePos,
	input wire logic lineNeg,
	input wire logic ampOk,
	output logic sigPresent,
	output logic overflow,
	output logic [19:0] bcdOut,
	output logic irq
);
	logic [3:0] syncA_reg, syncB_reg, syncC_reg, filt_reg;
	logic linkPrev_reg, linkRise;
	logic [4:0] perCnt_reg, perLo, perHi;
	logic [3:0] goodRun_reg;
	logic presNext, sigPres_reg;
	logic total_reg, chk_reg, injPend_reg;
	cvm_code_e code_reg;
	logic [1:0] rate_reg;
	cvm_state_e state_reg;
	logic running;
	logic [19:0] cnt_reg, res_reg, bcd_reg, cntStep, slot_reg;
	logic ovf_reg, cntUp, atMax, winEnd;
	logic [3:0] ist_reg, imsk_reg, irqEv;
	logic irq_reg;
	logic wrEn, wrCtrl, mapW, mapR;
	logic startStb, stopStb, clrStb, injStb;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, rdMux;
	cvm_sym_if symBus();
	// Supported-code mask as a vector so a code value can index it.
	localparam logic [3:0] CODES_OK = `CVM_CODES_OK;

	// Five-digit BCD increment, digit by digit with carry.
	function automatic logic [19:0] bcdInc(input logic [19:0] v);
		logic [19:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (c) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Slot period window in clk_sys cycles, half to one and a half nominal.
	function automatic logic [4:0] slotLim(input logic [1:0] rate, input logic hi);
		int kbps;
		int lim;
		kbps = `CVM_KBPS_8448;
		case (rate)
			2'h0: kbps = `CVM_KBPS_1544;
			2'h1: kbps = `CVM_KBPS_2048;
			2'h2: kbps = `CVM_KBPS_6312;
			default: kbps = `CVM_KBPS_8448;
		endcase
		lim = hi ? (3 * `CVM_SYS_KHZ + 2 * kbps - 1) / (2 * kbps)
			: `CVM_SYS_KHZ / (2 * kbps);
		if (lim < 1) begin
			lim = 1;
		end
		return 5'(lim);
	endfunction

	// Pin inputs pass three flops; a level counts once stages two and three agree.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
			syncC_reg <= 4'h0;
			filt_reg <= 4'h0;
			linkPrev_reg <= 1'b0;
		end else begin
			syncA_reg <= {ampOk, lineNeg, linePos, linkClk};
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			filt_reg <= (filt_reg & ~(syncB_reg ~^ syncC_reg))
				| (syncC_reg & (syncB_reg ~^ syncC_reg));
			linkPrev_reg <= filt_reg[0];
		end
	end

	// The recovered clock rises mid-slot; rails are taken only at that edge.
	// R8 - mid-slot gate
	assign linkRise = filt_reg[0] & ~linkPrev_reg;

	// Symbol strobe to the detector; an armed injection flips one mark.
	// R15 - input path check
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			symBus.symValid <= 1'b0;
			symBus.symPos <= 1'b0;
			symBus.symNeg <= 1'b0;
			injPend_reg <= 1'b0;
		end else begin
			symBus.symValid <= linkRise;
			if (linkRise) begin
				// R16 - flipped mark
				if (injPend_reg && (filt_reg[1] ^ filt_reg[2])) begin
					symBus.symPos <= filt_reg[2];
					symBus.symNeg <= filt_reg[1];
					injPend_reg <= injStb;
				end else begin
					symBus.symPos <= filt_reg[1] & ~filt_reg[2];
					symBus.symNeg <= filt_reg[2] & ~filt_reg[1];
					injPend_reg <= injPend_reg | injStb;
				end
			end else begin
				injPend_reg <= injPend_reg | injStb;
			end
		end
	end
	assign symBus.code = code_reg;

	cvm_cv_detect u_detect (
		.clk_sys(clk_sys),
		.rst(rst),
		.sym(symBus.det)
	);

	// Presence needs amplitude and a run of slot periods in range.
	// R6 - rate timing
	assign perLo = slotLim(rate_reg, 1'b0);
	assign perHi = slotLim(rate_reg, 1'b1);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			perCnt_reg <= 5'h00;
			goodRun_reg <= 4'h0;
		end else if (linkRise) begin
			perCnt_reg <= 5'h01;
			if (perCnt_reg >= perLo && perCnt_reg <= perHi) begin
				if (goodRun_reg != `CVM_PRES_RUN) begin
					goodRun_reg <= goodRun_reg + 4'h1;
				end
			end else begin
				goodRun_reg <= 4'h0;
			end
		end else begin
			if (perCnt_reg != 5'h1F) begin
				perCnt_reg <= perCnt_reg + 5'h01;
			end
			if (perCnt_reg > perHi) begin
				goodRun_reg <= 4'h0;
			end
		end
	end
	// R9 - signal present
	assign presNext = filt_reg[3] & (goodRun_reg == `CVM_PRES_RUN);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sigPres_reg <= 1'b0;
		end else begin
			sigPres_reg <= presNext;
		end
	end

	// Register writes take address and data together; lanes gate fields.
	assign wrEn = awvalid & wvalid & ~bvalid_reg;
	assign wrCtrl = wrEn & (awaddr == `CVM_OFS_CTRL);
	assign startStb = wrCtrl & wstrb[0] & wdata[`CVM_B_START];
	assign stopStb = wrCtrl & wstrb[0] & wdata[`CVM_B_STOP];
	assign clrStb = wrCtrl & wstrb[0] & wdata[`CVM_B_CLR];
	assign injStb = wrCtrl & wstrb[0] & wdata[`CVM_B_INJ];
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			total_reg <= 1'b0;
			chk_reg <= 1'b0;
			code_reg <= CODE_AMI;
			rate_reg <= 2'h0;
			imsk_reg <= `CVM_MSK_RST;
		end else begin
			if (wrCtrl && wstrb[0]) begin
				total_reg <= wdata[`CVM_B_TOTAL];
				chk_reg <= wdata[`CVM_B_CHK];
			end
			// R7 - unsupported codes ignored
			if (wrCtrl && wstrb[1] && CODES_OK[wdata[`CVM_F_CODE]]) begin
				code_reg <= cvm_code_e'(wdata[`CVM_F_CODE]);
				rate_reg <= wdata[`CVM_F_RATE];
			end
			if (wrEn && awaddr == `CVM_OFS_IMSK && wstrb[0]) begin
				imsk_reg <= wdata[3:0];
			end
		end
	end

	// Start and stop; stop wins when both are written at once.
	// R13 - start and stop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: if (startStb && !stopStb) state_reg <= ST_RUN;
				ST_RUN: if (stopStb) state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	assign running = (state_reg == ST_RUN);

	// Check mode counts every cycle to walk the counter and display.
	// R19 - gated by presence
	assign cntUp = running & (chk_reg | (sigPres_reg & symBus.violation));
	assign atMax = (cnt_reg == `CVM_CNT_MAX);
	// R18 - saturate at maximum
	assign cntStep = (cntUp && !atMax) ? bcdInc(cnt_reg) : cnt_reg;
	// R10 - window of slots
	assign winEnd = running & sigPres_reg & ~total_reg & symBus.symValid
		& (slot_reg == 20'(WIN_SLOTS - 1));

	// Violation counter; in rate mode each window lands in the result.
	// R14 - clear all
	always_ff @(posedge clk_sys) begin
		if (rst || clrStb) begin
			cnt_reg <= 20'h00000;
			ovf_reg <= 1'b0;
			res_reg <= 20'h00000;
			slot_reg <= 20'h00000;
		end else if (winEnd) begin
			res_reg <= cntStep;
			cnt_reg <= 20'h00000;
			ovf_reg <= 1'b0;
			slot_reg <= 20'h00000;
		end else begin
			cnt_reg <= cntStep;
			// R12 - overflow flag
			if (cntUp && atMax) begin
				ovf_reg <= 1'b1;
			end
			// R11 - total mode keeps summing
			if (running && sigPres_reg && !total_reg && symBus.symValid) begin
				slot_reg <= slot_reg + 20'h00001;
			end
		end
	end

	// Parallel BCD result: running total, or the last window's count.
	// R17 - BCD output
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bcd_reg <= 20'h00000;
		end else begin
			bcd_reg <= total_reg ? cnt_reg : res_reg;
		end
	end

	// Sticky events; a new event beats a write-one-to-clear in the same cycle.
	assign irqEv[`CVM_I_WIN] = winEnd;
	assign irqEv[`CVM_I_OVF] = cntUp & atMax & ~ovf_reg & ~clrStb;
	assign irqEv[`CVM_I_LOS] = sigPres_reg & ~presNext;
	assign irqEv[`CVM_I_CV] = running & sigPres_reg & symBus.violation;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ist_reg <= 4'h0;
			irq_reg <= 1'b0;
		end else begin
			if (wrEn && awaddr == `CVM_OFS_IST && wstrb[0]) begin
				ist_reg <= (ist_reg & ~wdata[3:0]) | irqEv;
			end else begin
				ist_reg <= ist_reg | irqEv;
			end
			irq_reg <= |(ist_reg & imsk_reg);
		end
	end

	// Write response, one cycle after the write is taken.
	assign mapW = (awaddr == `CVM_OFS_CTRL) | (awaddr == `CVM_OFS_IST)
		| (awaddr == `CVM_OFS_IMSK);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
		end else if (wrEn) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= mapW ? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read mux; unmapped reads return zero with a slave error.
	always_comb begin
		mapR = 1'b1;
		rdMux = 32'h00000000;
		case (araddr)
			`CVM_OFS_CTRL: rdMux = {20'h00000, rate_reg, code_reg, 2'h0,
				1'b0, chk_reg, total_reg, 3'h0};
			`CVM_OFS_STAT: rdMux = {29'h00000000, ovf_reg, running, sigPres_reg};
			`CVM_OFS_CNT: rdMux = {12'h000, cnt_reg};
			`CVM_OFS_RES: rdMux = {12'h000, res_reg};
			`CVM_OFS_IST: rdMux = {28'h0000000, ist_reg};
			`CVM_OFS_IMSK: rdMux = {28'h0000000, imsk_reg};
			default: mapR = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'h0;
		end else if (arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rdMux;
			rresp_reg <= mapR ? 2'h0 : 2'h2;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign awready = wrEn;
	assign wready = wrEn;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = ~rvalid_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign sigPresent = sigPres_reg;
	assign overflow = ovf_reg;
	assign bcdOut = bcd_reg;
	assign irq = irq_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_ovfMax;
		ovf_reg |-> cnt_reg == `CVM_CNT_MAX;
	endproperty
	a_ovfMax: assert property (p_ovfMax) else $error("overflow without max"); // R12
	property p_ovfHold;
		ovf_reg && !clrStb && !winEnd |=> ovf_reg && $stable(cnt_reg);
	endproperty
	a_ovfHold: assert property (p_ovfHold) else $error("overflow not held"); // R18
	property p_noSig;
		!sigPres_reg && !chk_reg && !clrStb |=> $stable(cnt_reg) && $stable(slot_reg);
	endproperty
	a_noSig: assert property (p_noSig) else $error("counting without signal"); // R19
	property p_idle;
		state_reg == ST_IDLE && !clrStb |=> $stable(cnt_reg);
	endproperty
	a_idle: assert property (p_idle) else $error("counting while stopped"); // R13
	property p_clear;
		clrStb |=> cnt_reg == 20'h00000 && !ovf_reg && res_reg == 20'h00000 ##1
			bcdOut == 20'h00000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear incomplete"); // R14
	property p_present;
		sigPresent |-> $past(filt_reg[3]) && $past(goodRun_reg) == `CVM_PRES_RUN;
	endproperty
	a_present: assert property (p_present) else $error("presence without cause"); // R9
	property p_window;
		slot_reg < 20'(WIN_SLOTS);
	endproperty
	a_window: assert property (p_window) else $error("window overrun"); // R10
	property p_total;
		total_reg && !clrStb && cntUp && !atMax |=> cnt_reg != 20'h00000;
	endproperty
	a_total: assert property (p_total) else $error("total lost"); // R11
	property p_start;
		state_reg == ST_IDLE && startStb && !stopStb |=> running;
	endproperty
	a_start: assert property (p_start) else $error("start ignored"); // R13
endmodule // cvm_monitor

// ===== test/cvm_line_model.sv
`timescale 1ns/100ps
// Line equipment model: a recovered clock and two rails, one symbol per slot.
module cvm_line_model (
	output logic linkClk,
	output logic linePos,
	output logic lineNeg,
	output logic ampOk
);
	// Idle state before the first frame.
	initial begin
		linkClk = 1'b0;
		linePos = 1'b0;
		lineNeg = 1'b1;
		ampOk = 1'b0;
	end

	// one symbol per slot
	// Rails move half a slot before the rising edge, so the sample lands mid-slot.
	// The odd start offset keeps link edges away from system clock edges.
	task automatic frame(input int q[$]);
		#13;
		ampOk = 1'b1;
		foreach (q[i]) begin
			linkClk = 1'b0;
			linePos = (q[i] > 0);
			lineNeg = (q[i] < 0);
			#200;
			linkClk = 1'b1;
			#200;
		end
		// Between frames the clock stands still and the rails carry no meaning.
		linkClk = 1'b0;
		linePos = ~linePos;
		lineNeg = ~lineNeg;
		ampOk = 1'b0;
	endtask
endmodule // cvm_line_model

// ===== test/code_violation_monitor_bench.sv
`timescale 1ns/100ps
`include "cvm_regs.svh"
module code_violation_monitor_bench;
	logic clk_sys;
	logic rst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, lfsrReg;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic linkClk, linePos, lineNeg, ampOk, sigPresent, overflow, irq;
	logic [19:0] bcdOut;
	int errTotal = 0;
	int testsRun = 0;
	int cycles = 0;
	int expCnt;
	int q[$];

	// A short window keeps rate mode quick.
	cvm_monitor #(.WIN_SLOTS(20)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.linkClk(linkClk), .linePos(linePos), .lineNeg(lineNeg), .ampOk(ampOk),
		.sigPresent(sigPresent), .overflow(overflow), .bcdOut(bcdOut), .irq(irq)
	);
	cvm_line_model u_line (.linkClk(linkClk), .linePos(linePos), .lineNeg(lineNeg), .ampOk(ampOk));

	// 20 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Watchdog; the whole run needs well under this many cycles.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			results();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] toBcd(input int v);
		logic [31:0] b;
		b = 32'h0;
		for (int k = 0; k < 5; k++) begin
			b[4 * k +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return b;
	endfunction

	function automatic logic [31:0] cfg(input int c, input int r, input logic tot, input logic chkm);
		return {20'h0, 2'(r), 2'(c), 3'h0, chkm, tot, 3'h0};
	endfunction

	// Reference count: same-polarity marks, bipolar violation pairs for the three-zero code,
	// and the substitution pattern excused for the six- and eight-zero codes.
	function automatic int model(input int c);
		int lm, lb, n, i, nz;
		lm = 0;
		lb = 0;
		n = 0;
		i = 0;
		nz = (c == 2) ? 1 : 3;
		while (i < q.size()) begin
			if (c >= 2 && lm != 0 && i >= nz && i + 4 < q.size() && q[i - 1] == 0
					&& q[i - nz] == 0 && (nz == 1 || q[i - 2] == 0) && q[i] == lm
					&& q[i + 1] == -lm && q[i + 2] == 0 && q[i + 3] == -lm && q[i + 4] == lm) begin
				i += 5;
			end else begin
				if (q[i] != 0 && q[i] == lm) begin
					if (c != 1 || lb == q[i]) n++;
					lb = q[i];
				end
				if (q[i] != 0) lm = q[i];
				i++;
			end
		end
		return n;
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			errTotal++;
		end
	endtask

	task automatic results();
		$display("Checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic rstDut();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	// Write: address and data offered together, held until both readies are seen.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		#1;
		while (!(awready && wready)) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		#1;
		while (!bvalid) begin
			@(posedge clk_sys);
			#1;
		end
		rs = bresp;
		@(posedge clk_sys);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		#1;
		while (!arready) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		arvalid <= 1'b0;
		#1;
		while (!rvalid) begin
			@(posedge clk_sys);
			#1;
		end
		rd = rdata;
		rs = rresp;
		@(posedge clk_sys);
		rready <= 1'b0;
	endtask

	// Zero preamble lets presence settle; the zero trailer flushes the detector look-ahead.
	task automatic build(input int c);
		int p;
		p = 1;
		q = {};
		repeat (10) q.push_back(0);
		q.push_back(p);
		repeat (30) begin
			lfsrReg = lfsr(lfsrReg);
			if (lfsrReg[1:0] == 2'h0) begin
				q.push_back(0);
			end else begin
				p = (lfsrReg[4:2] == 3'h0) ? p : -p;
				q.push_back(p);
			end
		end
		if (c >= 2) begin
			repeat ((c == 2) ? 1 : 3) q.push_back(0);
			q = {q, p, -p, 0, -p, p};
		end
		q.push_back(p);
		repeat (12) q.push_back(0);
	endtask

	task automatic runFrame(input logic e);
		fork
			u_line.frame(q);
			begin
				repeat (160) @(posedge clk_sys);
				#1;
				chk("sigPresent", {31'h0, e}, {31'h0, sigPresent});
			end
		join
		repeat (40) @(posedge clk_sys);
		#1;
		chk("sigLost", 32'h0, {31'h0, sigPresent});
	endtask

	// Main sequence.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		lfsrReg = 32'hA6AD891E;
		rstDut();
		chk("outputs", 32'h0, {9'h0, sigPresent, overflow, irq, bcdOut});
		axr(`CVM_OFS_STAT);
		chk("STAT", 32'h0, rd);
		axr(`CVM_OFS_IMSK);
		chk("IMSK", 32'h0, rd);
		axr(8'h18);
		chk("unmapped read", 32'h2, {rd[29:0], rs});
		axw(8'h18, 32'hFFFFFFFF);
		chk("unmapped write", 32'h2, {30'h0, rs});
		// Every line code in total mode, alternating the two rates a 400 ns slot fits.
		for (int c = 0; c < 4; c++) begin
			rstDut();
			axw(`CVM_OFS_CTRL, cfg(c, c % 2, 1'b1, 1'b0));
			axw(`CVM_OFS_CTRL, cfg(c, c % 2, 1'b1, 1'b0) | 32'h1);
			build(c);
			expCnt = model(c);
			runFrame(1'b1);
			axr(`CVM_OFS_CNT);
			chk("CNT", toBcd(expCnt), rd);
			chk("bcdOut", toBcd(expCnt), {12'h0, bcdOut});
			axr(`CVM_OFS_IST);
			chk("IST", {30'h0, expCnt > 0, 1'b1}, {30'h0, rd[3:2]});
		end
		// Masked status keeps the line low; unmasking raises it, write-one clears it.
		chk("irq masked", 32'h0, {31'h0, irq});
		axw(`CVM_OFS_IMSK, 32'h4);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		axw(`CVM_OFS_IST, 32'hF);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		axr(`CVM_OFS_IST);
		chk("IST cleared", 32'h0, {28'h0, rd[3:0]});
		// Clear wipes counter, overflow and the total-mode display.
		axw(`CVM_OFS_CTRL, cfg(3, 1, 1'b1, 1'b0) | 32'h4);
		repeat (2) @(posedge clk_sys);
		#1;
		axr(`CVM_OFS_CNT);
		chk("CNT cleared", 32'h0, rd);
		chk("bcdOut cleared", 32'h0, {11'h0, overflow, bcdOut});
		// After stop a second frame with violations adds nothing.
		rstDut();
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b0));
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b0) | 32'h1);
		build(0);
		expCnt = model(0);
		runFrame(1'b1);
		axr(`CVM_OFS_STAT);
		chk("run", 32'h1, {31'h0, rd[1]});
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b0) | 32'h2);
		build(0);
		runFrame(1'b1);
		axr(`CVM_OFS_CNT);
		chk("CNT stopped", toBcd(expCnt), rd);
		// Input-path check: an armed injection flips the first mark of the frame.
		rstDut();
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b0));
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b0) | 32'h21);
		build(0);
		q[10] = -q[10];
		expCnt = model(0);
		q[10] = -q[10];
		runFrame(1'b1);
		axr(`CVM_OFS_CNT);
		chk("CNT injected", toBcd(expCnt), rd);
		// Rates whose slot a 400 ns clock cannot match: no presence, so no count.
		for (int r = 2; r < 4; r++) begin
			rstDut();
			axw(`CVM_OFS_CTRL, cfg(0, r, 1'b1, 1'b0));
			axw(`CVM_OFS_CTRL, cfg(0, r, 1'b1, 1'b0) | 32'h1);
			build(0);
			runFrame(1'b0);
			axr(`CVM_OFS_CNT);
			chk("CNT absent", 32'h0, rd);
		end
		// Rate mode with a short window must flag a window end.
		rstDut();
		axw(`CVM_OFS_CTRL, cfg(1, 1, 1'b0, 1'b0));
		axw(`CVM_OFS_CTRL, cfg(1, 1, 1'b0, 1'b0) | 32'h1);
		build(1);
		runFrame(1'b1);
		axr(`CVM_OFS_IST);
		chk("window", 32'h1, {31'h0, rd[0]});
		// Check mode counts system cycles without any line signal.
		rstDut();
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b1));
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b1) | 32'h1);
		repeat (40) @(posedge clk_sys);
		axw(`CVM_OFS_CTRL, cfg(0, 0, 1'b1, 1'b1) | 32'h2);
		axr(`CVM_OFS_CNT);
		chk("check count", 32'h1, {31'h0, rd > toBcd(39) && rd < toBcd(52)});
		results();
	end
endmodule // code_violation_monitor_bench
